// *** include/setpoint_defines.svh ***
`ifndef SETPOINT_DEFINES_SVH
`define SETPOINT_DEFINES_SVH
`define SP_ADDR 8'h19
`define RAMP_ADDR 8'h1a
`define SP_RESET 8'ha2
`define SP_RESET_ALT 8'h22
`define RAMP_RESET 8'h06
`define SP_SKIP_BIT 7
`define RAMP_GO_BIT 7
`define RAMP_HOLD_BIT 6
`define SP_CODE_MAX 6'h34
`define SP_WMASK 8'hbf
`define RAMP_WMASK 8'hc7
`define BLANK_TIME_MS 5
`define CLK_MHZ 125
`define BLANK_CYCLES (`BLANK_TIME_MS * 1000 * `CLK_MHZ)
`endif

// *** include/setpoint_pkg.sv ***
package setpoint_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b01,
    RAMP_BUSY = 2'b10
  } ramp_state_e;
endpackage : setpoint_pkg

// *** design/buck_boost_setpoint_regs.sv ***
`timescale 1ns/1ps
`include "setpoint_defines.svh"

// What this block does
// - Setpoint register at subaddress 19h, resets to a2h.
// - Setpoint writes accepted only while the password unlock is satisfied.
// - Each accepted setpoint write blanks voltage monitors for 5 ms.
// - Bit 7 pulse-skip enable, reset 1; 0 forces fixed-frequency PWM.
// - Bits 5-0 voltage code, reset 22h, 1.175 V plus steps.
// - Power-up setpoint is reloaded from the default-select resistor input, a2h at either level.
// - Ramp register 1Ah, reset 06h, drives core bucks only.
// - Ramp go bit starts core buck ramp, clears when done.
module buck_boost_setpoint_regs #(
  parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register access from the serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire setpoint_pkg::reg_byte_t reg_wdata,
  output setpoint_pkg::reg_byte_t reg_rdata,
  input wire logic password_ok,
  // Power-up strap
  input wire logic default_select_resistor,
  // Converter side
  output logic light_load_skip_enable,
  output logic [5:0] buck_boost_voltage_code,
  output logic monitor_blank,
  output logic core_ramp_start,
  output logic [2:0] core_ramp_rate,
  output logic core_ramp_hold_off,
  input wire logic core_ramp_done
);
  import setpoint_pkg::*;

  initial begin
    if (BLANK_CYCLES < 2) begin
      $error("BLANK_CYCLES too small");
    end
  end

  reg_byte_t setpoint_q;
  reg_byte_t ramp_q;
  logic [31:0] blank_cnt_q;
  logic strap_taken_q;
  logic [2:0] sel_sync_q;
  // Counts synchroniser fill, so the reset zeros are never taken as the strap
  logic [1:0] sync_fill_q;
  ramp_state_e ramp_state_q;
  logic sp_wr;
  logic ramp_wr;
  logic go_set;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  assign sp_wr = clk_en && reg_wr && password_ok && hit(reg_addr, `SP_ADDR);
  assign ramp_wr = clk_en && reg_wr && hit(reg_addr, `RAMP_ADDR);
  assign go_set = ramp_wr && reg_wdata[`RAMP_GO_BIT];

  // Strap is a pin: three stages, change when last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_sync_q <= 3'h0;
      sync_fill_q <= 2'h0;
    end else if (clk_en) begin
      sel_sync_q <= {sel_sync_q[1:0], default_select_resistor};
      if (sync_fill_q != 2'h3) begin
        sync_fill_q <= sync_fill_q + 2'h1;
      end
    end
  end

  // reset value, strap load, bit 6 masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setpoint_q <= `SP_RESET;
      strap_taken_q <= 1'b0;
    end else if (clk_en) begin
      if (sp_wr) begin
        setpoint_q <= reg_wdata & `SP_WMASK;
        strap_taken_q <= 1'b1;
      end else if (!strap_taken_q && sync_fill_q == 2'h3
                   && sel_sync_q[2] == sel_sync_q[1]) begin
        // Strap picks 22h|80h or a2h, both the same code a2h; skip enable stays set
        setpoint_q <= sel_sync_q[2] ? `SP_RESET_ALT | 8'h80 : `SP_RESET;
        strap_taken_q <= 1'b1;
      end
    end
  end

  // blanking counter restarts on every accepted setpoint write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_cnt_q <= 32'h0;
    end else if (clk_en) begin
      if (sp_wr) begin
        blank_cnt_q <= BLANK_CYCLES;
      end else if (blank_cnt_q != 32'h0) begin
        blank_cnt_q <= blank_cnt_q - 32'h1;
      end
    end
  end

  // ramp register, go bit: set wins over done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_q <= `RAMP_RESET;
      ramp_state_q <= RAMP_IDLE;
    end else if (clk_en) begin
      if (ramp_wr) begin
        ramp_q <= reg_wdata & `RAMP_WMASK;
      end
      case (ramp_state_q)
        RAMP_IDLE: begin
          if (go_set) begin
            ramp_state_q <= RAMP_BUSY;
          end
        end
        RAMP_BUSY: begin
          if (core_ramp_done && !go_set) begin
            ramp_q[`RAMP_GO_BIT] <= 1'b0;
            ramp_state_q <= RAMP_IDLE;
          end
        end
        default: begin
          ramp_state_q <= RAMP_IDLE;
        end
      endcase
    end
  end

  assign light_load_skip_enable = setpoint_q[`SP_SKIP_BIT];
  assign buck_boost_voltage_code = setpoint_q[5:0];
  assign monitor_blank = blank_cnt_q != 32'h0;
  assign core_ramp_start = go_set;
  assign core_ramp_rate = ramp_q[2:0];
  assign core_ramp_hold_off = ramp_q[`RAMP_HOLD_BIT];

  always_comb begin
    reg_rdata = 8'h00;
    if (hit(reg_addr, `SP_ADDR)) begin
      reg_rdata = setpoint_q;
    end else if (hit(reg_addr, `RAMP_ADDR)) begin
      reg_rdata = ramp_q;
    end
  end

  a_bit6_zero: assert property (@(posedge clk) disable iff (rst)
    setpoint_q[6] == 1'b0) else $error("bit 6 set");
  a_locked_hold: assert property (@(posedge clk) disable iff (rst)
    (clk_en && reg_wr && hit(reg_addr, `SP_ADDR) && !password_ok
     && strap_taken_q) |=> $stable(setpoint_q))
    else $error("locked write changed setpoint");
  a_write_takes: assert property (@(posedge clk) disable iff (rst)
    sp_wr |=> setpoint_q == ($past(reg_wdata) & `SP_WMASK))
    else $error("write lost");
  a_blank_start: assert property (@(posedge clk) disable iff (rst)
    sp_wr |=> monitor_blank && blank_cnt_q == BLANK_CYCLES)
    else $error("blank not started");
  a_blank_ends: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !sp_wr && blank_cnt_q == 32'h1) |=> !monitor_blank)
    else $error("blank overran");
  a_blank_step: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !sp_wr && blank_cnt_q != 32'h0)
    |=> blank_cnt_q == $past(blank_cnt_q) - 32'h1)
    else $error("blank step wrong");
  // frozen while disabled; a stalled clock enable stretches the blank
  a_freeze_state: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(blank_cnt_q) && $stable(setpoint_q)
    && $stable(ramp_q))
    else $error("state moved while disabled");
  a_go_clear: assert property (@(posedge clk) disable iff (rst)
    (clk_en && ramp_state_q == RAMP_BUSY && core_ramp_done && !go_set)
    |=> !ramp_q[`RAMP_GO_BIT]) else $error("go not cleared");
  a_go_busy: assert property (@(posedge clk) disable iff (rst)
    (clk_en && go_set) |=> ramp_state_q == RAMP_BUSY
    && ramp_q[`RAMP_GO_BIT]) else $error("go not started");
  a_ramp_rsvd: assert property (@(posedge clk) disable iff (rst)
    ramp_q[5:3] == 3'h0) else $error("ramp reserved set");
  a_ramp_no_bb: assert property (@(posedge clk) disable iff (rst)
    (ramp_wr && strap_taken_q) |=> $stable(setpoint_q))
    else $error("ramp write moved setpoint");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    (!hit(reg_addr, `SP_ADDR) && !hit(reg_addr, `RAMP_ADDR))
    |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_skip_out: assert property (@(posedge clk) disable iff (rst)
    light_load_skip_enable == setpoint_q[7])
    else $error("skip mismatch");
  c_sp_write: cover property (@(posedge clk) sp_wr);
  c_blank_restart: cover property (@(posedge clk) sp_wr && monitor_blank);
  c_locked: cover property (@(posedge clk)
    clk_en && reg_wr && hit(reg_addr, `SP_ADDR) && !password_ok);
  c_go_done: cover property (@(posedge clk)
    ramp_state_q == RAMP_BUSY ##1 ramp_state_q == RAMP_IDLE);
endmodule : buck_boost_setpoint_regs

// *** tb/ramp_partner.sv ***
`timescale 1ns/1ps
module ramp_partner (
  // Ramp handshake with the core bucks
  input wire logic clk,
  input wire logic core_ramp_start,
  output logic core_ramp_done
);
  int n;
  initial core_ramp_done = 1'b0;
  // Ramp takes a few cycles, so the go bit is seen standing before it clears
  always @(posedge clk) begin
    if (core_ramp_start) n <= 6;
    else if (n > 0) n <= n - 1;
    core_ramp_done <= (n == 1);
  end
endmodule : ramp_partner

// *** tb/buck_boost_setpoint_regs_tb.sv ***
`timescale 1ns/1ps
`include "setpoint_defines.svh"
`define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module buck_boost_setpoint_regs_tb;
  import setpoint_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, pw = 0, look = 0, cen = 1, sel = 0;
  logic done, skip, blank, go, hold;
  logic [7:0] addr = 0;
  logic [5:0] code;
  logic [2:0] rate;
  reg_byte_t wd = 0, rd, e, r;
  reg_byte_t q[$];
  int miscompares = 0, n_tests = 0, seed = 79;
  initial forever #4 clk = ~clk;
  buck_boost_setpoint_regs #(.BLANK_CYCLES(20)) u_buck_boost_setpoint_regs (
    .clk(clk), .rst(rst), .clk_en(cen), .reg_wr(reg_wr), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rd), .password_ok(pw),
    .default_select_resistor(sel), .light_load_skip_enable(skip),
    .buck_boost_voltage_code(code), .monitor_blank(blank),
    .core_ramp_start(go), .core_ramp_rate(rate),
    .core_ramp_hold_off(hold), .core_ramp_done(done));
  ramp_partner u_ramp_partner (.clk(clk), .core_ramp_start(go),
    .core_ramp_done(done));
  task wr(input logic [7:0] a, input reg_byte_t d);
    @(negedge clk);
    addr = a;
    wd = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask : wr
  task rdx(input logic [7:0] a, input reg_byte_t x);
    @(negedge clk);
    addr = a;
    q.push_back(x);
    look = 1;
    @(negedge clk);
    look = 0;
  endtask : rdx
  // Read data is combinational, so it is taken at the edge of the read cycle
  always @(posedge clk) if (look) begin
    e = q.pop_front();
    `CMP(rd, e)
  end
  task wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    sel = $random(seed);
    repeat (12) @(negedge clk);
    rst = 0;
    // Leave time for the strap synchroniser to load its value
    repeat (6) @(negedge clk);
    rdx(`SP_ADDR, `SP_RESET);
    rdx(`RAMP_ADDR, `RAMP_RESET);
    rdx(8'h1b, 8'h00);
    `CMP(skip, 1'b1)
    `CMP(code, 6'h22)
    wr(`SP_ADDR, 8'h45);
    rdx(`SP_ADDR, `SP_RESET);
    `CMP(blank, 1'b0)
    pw = 1;
    wr(`SP_ADDR, 8'h45);
    `CMP(blank, 1'b1)
    rdx(`SP_ADDR, 8'h05);
    `CMP({skip, code}, 7'h05)
    repeat (25) @(negedge clk);
    `CMP(blank, 1'b0)
    // host duty, core skip bits outside
    wr(`RAMP_ADDR, 8'hff);
    rdx(`RAMP_ADDR, 8'hc7);
    `CMP(blank, 1'b0)
    `CMP({hold, rate}, 4'hf)
    repeat (10) @(negedge clk);
    rdx(`RAMP_ADDR, 8'h47);
    `CMP({skip, code}, 7'h05)
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      r[5:0] = r[5:0] % 6'h35;
      wr(`SP_ADDR, r);
      `CMP({skip, code}, {r[7], r[5:0]})
      rdx(`SP_ADDR, r & `SP_WMASK);
    end
    cen = 0;
    wr(`SP_ADDR, 8'h00);
    `CMP({skip, code}, {r[7], r[5:0]})
    cen = 1;
    // Mid-run reset must bring both registers back
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    repeat (6) @(negedge clk);
    rdx(`SP_ADDR, `SP_RESET);
    rdx(`RAMP_ADDR, `RAMP_RESET);
    wrap_up();
  end
endmodule : buck_boost_setpoint_regs_tb
